// file: logic/sfc_control.sv
// Serial port control register and frame sync / slave select generator.
// Assumes an APB master on clk, and an SPI engine that pulses charDone per character.
// Overview of operation
// - framed enable bit 31 turns the select pin into frame sync.
// - bit 30 set makes frame sync an input, cleared an output.
// - bit 29 selects active-high frame pulse when set, low when cleared.
// - bit 28 in unframed master mode drives select automatically with frame polarity.
// - bit 27 makes generated pulse one character wide, else one sck period wide.
// - count field codes 0..5 give 1..32 characters per pulse; 6,7 reserved.
// - bit 23 picks reference clock for baud generator, else bus clock.
// - baud select and enhanced buffer bits change only while module off.
// - clock edge bit is ignored in framed mode; software should clear it.
// - audio enable forces effective clock polarity to one.
// - bits 22 to 18 read zero and ignore writes.
`timescale 1ns/1ps
`include "sfc_consts.svh"

module sfc_control
   import sfc_pkg::*;
#(
   parameter int SCK_HALF = `SFC_SCK_HALF_DEFAULT,
   parameter int CHAR_BITS = `SFC_CHAR_BITS_DEFAULT
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic txActive,
   input wire logic charDone,
   input wire logic selectIn,
   output logic selectOut,
   output logic selectOe,
   output logic frameStart,
   output logic sckTick,
   output logic baudFromRef,
   output logic effClockPolarity,
   output logic effClockEdge,
   output logic moduleOn
);

   // ==========================================================
   // Register bus
   logic [31:0] ctrlReg;
   sfc_ctrl_t ctrl;
   logic wrEn;
   logic addrCtrl;
   logic addrStatus;
   logic [31:0] statusWord;
   logic [31:0] next_ctrl;

   assign addrCtrl = (paddr == `SFC_CTRL_OFFSET);
   assign addrStatus = (paddr == `SFC_STATUS_OFFSET);
   assign wrEn = psel && penable && pwrite && addrCtrl;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(addrCtrl || (addrStatus && !pwrite));

   always_comb begin
      next_ctrl = pwdata & `SFC_CTRL_IMPL_MASK;
      if (ctrlReg[`SFC_MODULE_ON_BIT]) begin
         next_ctrl[`SFC_BAUD_SEL_BIT] = ctrlReg[`SFC_BAUD_SEL_BIT];
         next_ctrl[`SFC_ENH_BUF_BIT] = ctrlReg[`SFC_ENH_BUF_BIT];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrlReg <= `SFC_CTRL_RESET;
      end else if (wrEn) begin
         ctrlReg <= next_ctrl;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= addrCtrl ? ctrlReg : (addrStatus ? statusWord : 32'h0000_0000);
      end
   end

   assign ctrl.framedEn = ctrlReg[`SFC_FRAMED_EN_BIT];
   assign ctrl.fsyncInput = ctrlReg[`SFC_FRAME_SYNC_SIGNAL_DIR_BIT];
   assign ctrl.framePolHigh = ctrlReg[`SFC_FRAME_POL_BIT];
   assign ctrl.autoSelect = ctrlReg[`SFC_AUTO_SEL_BIT];
   assign ctrl.pulseCharWide = ctrlReg[`SFC_PULSE_WIDTH_BIT];
   assign ctrl.frameCount = ctrlReg[`SFC_COUNT_HI:`SFC_COUNT_LO];
   assign ctrl.baudFromRef = ctrlReg[`SFC_BAUD_SEL_BIT];
   assign ctrl.enhancedBuffer = ctrlReg[`SFC_ENH_BUF_BIT];
   assign ctrl.moduleOn = ctrlReg[`SFC_MODULE_ON_BIT];
   assign ctrl.clockEdge = ctrlReg[`SFC_EDGE_SEL_BIT];
   assign ctrl.clockPolarity = ctrlReg[`SFC_CLK_POL_BIT];
   assign ctrl.master = ctrlReg[`SFC_MASTER_BIT];
   assign ctrl.audioEn = ctrlReg[`SFC_AUDIO_BIT];

   // ==========================================================
   // Effective settings
   assign baudFromRef = ctrl.baudFromRef;
   assign effClockPolarity = ctrl.clockPolarity | ctrl.audioEn;
   assign effClockEdge = ctrl.framedEn ? 1'b0 : ctrl.clockEdge;
   assign moduleOn = ctrl.moduleOn;

   // ==========================================================
   // Serial clock tick, one enable pulse per sck period
   logic [15:0] divCount;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         divCount <= 16'h0000;
      end else if (!ctrl.moduleOn || divCount == 16'(2 * SCK_HALF - 1)) begin
         divCount <= 16'h0000;
      end else begin
         divCount <= divCount + 16'h0001;
      end
   end
   assign sckTick = ctrl.moduleOn && (divCount == 16'(2 * SCK_HALF - 1));

   // ==========================================================
   // Incoming frame sync, three-stage synchroniser
   logic [2:0] selSync;
   logic selStable;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         selSync <= 3'b000;
         selStable <= 1'b0;
      end else begin
         selSync <= {selSync[1:0], selectIn};
         if (selSync[1] == selSync[2]) begin
            selStable <= selSync[2];
         end
      end
   end

   logic selActive;
   logic selActiveDly;
   assign selActive = (selStable == ctrl.framePolHigh);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         selActiveDly <= 1'b0;
      end else begin
         selActiveDly <= selActive;
      end
   end

   // ==========================================================
   // Frame generator
   sfc_state_t state;
   logic [5:0] charCount;
   logic [5:0] charsPerPulse;
   logic genFrame;
   logic pulseOn;

   // Reserved codes fall back to one character per pulse
   assign charsPerPulse = (ctrl.frameCount <= `SFC_COUNT_MAX_CODE) ?
      6'(1 << ctrl.frameCount) : 6'd1;
   assign genFrame = ctrl.moduleOn && ctrl.framedEn && !ctrl.fsyncInput;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= SFC_IDLE;
         charCount <= 6'd0;
         pulseOn <= 1'b0;
      end else if (!genFrame) begin
         state <= SFC_IDLE;
         charCount <= 6'd0;
         pulseOn <= 1'b0;
      end else begin
         unique case (state)
            SFC_IDLE: begin
               if (txActive && sckTick) begin
                  state <= SFC_FRAME;
                  pulseOn <= 1'b1;
                  charCount <= 6'd0;
               end
            end
            SFC_FRAME: begin
               if (!ctrl.pulseCharWide && sckTick) begin
                  pulseOn <= 1'b0;
               end
               if (charDone) begin
                  if (ctrl.pulseCharWide && charCount == 6'd0) begin
                     pulseOn <= 1'b0;
                  end
                  if (charCount == charsPerPulse - 6'd1) begin
                     state <= SFC_GAP;
                  end else begin
                     charCount <= charCount + 6'd1;
                  end
               end
            end
            SFC_GAP: begin
               pulseOn <= 1'b0;
               state <= SFC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         frameStart <= 1'b0;
      end else if (ctrl.framedEn && ctrl.fsyncInput) begin
         frameStart <= selActive && !selActiveDly;
      end else begin
         frameStart <= genFrame && state == SFC_IDLE && txActive && sckTick;
      end
   end

   // ==========================================================
   // Select pin drive
   logic autoSel;
   assign autoSel = ctrl.moduleOn && !ctrl.framedEn && ctrl.autoSelect && ctrl.master;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         selectOe <= 1'b0;
         selectOut <= 1'b0;
      end else if (genFrame) begin
         selectOe <= 1'b1;
         selectOut <= pulseOn ~^ ctrl.framePolHigh ? 1'b1 : 1'b0;
      end else if (autoSel) begin
         selectOe <= 1'b1;
         selectOut <= txActive ? ctrl.framePolHigh : !ctrl.framePolHigh;
      end else begin
         selectOe <= 1'b0;
         selectOut <= 1'b0;
      end
   end

   assign statusWord = {27'h000_0000, selStable, selectOe, pulseOn, state};

endmodule : sfc_control

// file: logic/sfc_consts.svh
// Constants for the serial framing control block: offsets, fields, reset values.
// Assumes inclusion by bare name from package and design files.
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH

// ==========================================================
// Register map (byte addresses)
`define SFC_CTRL_OFFSET 12'h000
`define SFC_STATUS_OFFSET 12'h004
`define SFC_CTRL_RESET 32'h0000_0000
`define SFC_CTRL_IMPL_MASK 32'hFF83_FFFF

// ==========================================================
// Control field positions
`define SFC_FRAMED_EN_BIT 31
`define SFC_FRAME_SYNC_SIGNAL_DIR_BIT 30
`define SFC_FRAME_POL_BIT 29
`define SFC_AUTO_SEL_BIT 28
`define SFC_PULSE_WIDTH_BIT 27
`define SFC_COUNT_HI 26
`define SFC_COUNT_LO 24
`define SFC_BAUD_SEL_BIT 23
`define SFC_SAMPLE_END_BIT 17
`define SFC_ENH_BUF_BIT 16
`define SFC_MODULE_ON_BIT 15
`define SFC_EDGE_SEL_BIT 8
`define SFC_SEL_EN_BIT 7
`define SFC_CLK_POL_BIT 6
`define SFC_MASTER_BIT 5
`define SFC_AUDIO_BIT 4

// ==========================================================
// Timing
`define SFC_CLK_HZ 20000000
`define SFC_SCK_HALF_DEFAULT 4
`define SFC_CHAR_BITS_DEFAULT 8
`define SFC_COUNT_MAX_CODE 3'h5

`endif

// file: logic/sfc_pkg.sv
// Types shared by the serial framing control block.
// Assumes sfc_consts.svh is on the include path.
`include "sfc_consts.svh"

package sfc_pkg;

   typedef enum logic [1:0] {SFC_IDLE, SFC_FRAME, SFC_GAP} sfc_state_t;

   // Decoded control settings
   typedef struct packed {
      logic framedEn;
      logic fsyncInput;
      logic framePolHigh;
      logic autoSelect;
      logic pulseCharWide;
      logic [2:0] frameCount;
      logic baudFromRef;
      logic enhancedBuffer;
      logic moduleOn;
      logic clockEdge;
      logic clockPolarity;
      logic master;
      logic audioEn;
   } sfc_ctrl_t;

endpackage : sfc_pkg

// file: verification/sfc_peer.sv
// Far-side peer on the select pin.
// Assumes the bench raises fire for three cycles per incoming frame pulse.
`timescale 1ns/1ps
module sfc_peer (
   input wire logic clk,
   input wire logic selectOut,
   input wire logic selectOe,
   input wire logic fire,
   input wire logic polHigh,
   output logic selectIn
);
   logic drive = 1'b0;
   always @(posedge clk) drive <= fire;
   // Released line goes to the pull-up, not the last level
   assign selectIn = selectOe ? selectOut : (drive ? polHigh : 1'b1);
endmodule : sfc_peer

// file: verification/sfc_props.sv
// Port assertions for sfc_control.
// Assumes one clock domain and the bind at the foot.
`timescale 1ns/1ps
module sfc_props (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic frameStart,
   input wire logic selectOe,
   input wire logic baudFromRef,
   input wire logic effClockPolarity,
   input wire logic effClockEdge,
   input wire logic moduleOn
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence ctrlWr;
      psel && penable && pwrite && paddr == 12'h000;
   endsequence
   // ==========
   // Checks
   chk_edge_ignored: assert property (ctrlWr ##0 pwdata[31] |=> !effClockEdge)
      else $error("edge not forced");
   chk_audio_pol: assert property (ctrlWr ##0 pwdata[4] |=> effClockPolarity)
      else $error("polarity not forced");
   chk_baud_lock: assert property (ctrlWr ##0 moduleOn |=> $stable(baudFromRef))
      else $error("baud select changed");
   chk_baud_load: assert property (ctrlWr ##0 !moduleOn |=> baudFromRef == $past(pwdata[23]))
      else $error("baud select lost");
   chk_unimpl_zero: assert property (psel && penable && !pwrite && paddr == 12'h000
      |-> prdata[22:18] == 5'h00)
      else $error("reserved bits set");
   chk_pulse_single: assert property (frameStart |=> !frameStart)
      else $error("frame start too long");
   chk_slave_release: assert property (ctrlWr ##0 pwdata[31:30] == 2'b11 |=> ##1 !selectOe)
      else $error("slave drives select");
   chk_off_release: assert property (ctrlWr ##0 pwdata[31:28] == 4'h0 |=> ##1 !selectOe)
      else $error("select driven while off");
endmodule : sfc_props
bind sfc_control sfc_props i_props (.*);

// file: verification/tb.sv
// Testbench for sfc_control with APB driver and select-pin peer.
// Assumes the package, design, peer and checker compile first.
`timescale 1ns/1ps
module tb;
   logic clk, reset, psel, penable, pwrite, txActive, charDone, fire, polHigh;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, selectIn, selectOut, selectOe, frameStart, sckTick;
   logic baudFromRef, effClockPolarity, effClockEdge, moduleOn;
   logic [1:0] expSel;
   logic [32:0] expQ[$];
   int num_errors = 0, n_checks = 0, starts = 0, ticks = 0;
   logic startDly = 1'b0;
   sfc_control i_dut (.*);
   sfc_peer i_peer (.*);
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   task automatic chk(string n, logic [32:0] e, logic [32:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up
   // Idle cycle after each transfer
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [32:0] e = 0);
      if (!wr) expQ.push_back(e);
      @(posedge clk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 0;
      penable <= 0;
      // Let the landed write settle before callers look at outputs
      @(posedge clk);
   endtask : apb
   // ==========
   // Result watcher
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite && expQ.size() > 0)
         chk("read", expQ.pop_front(), {pslverr, prdata});
      if (sckTick === 1'b1) ticks++;
      if (frameStart === 1'b1) starts++;
      // Select drive is registered from the pulse flag, one cycle behind frameStart
      startDly <= (frameStart === 1'b1);
      if (startDly) begin
         chk("select", {31'h0, expSel}, {31'h0, selectOe, selectOe & selectOut});
      end
   end
   initial begin
      #1_000_000;
      num_errors++;
      wrap_up();
   end
   // ==========
   // Scenarios
   initial begin
      logic [31:0] r;
      {reset, psel, penable, pwrite, txActive, charDone, fire, polHigh} = 8'h80;
      paddr = 0;
      pwdata = 0;
      expSel = 0;
      r = $urandom(4);
      repeat (6) @(posedge clk);
      reset <= 0;
      apb(0, 12'h000, 0, 0);
      apb(1, 12'h000, 32'hFFFF_FFFF);
      apb(0, 12'h000, 0, {1'b0, 32'hFF83_FFFF});
      apb(1, 12'h000, 0);
      apb(0, 12'h000, 0, {1'b0, 32'h0081_0000});
      chk("baud", 1, baudFromRef);
      apb(1, 12'h000, 0);
      chk("baud", 0, baudFromRef);
      repeat (4) begin
         r = $urandom & 32'hFFFF_7FFF;
         apb(1, 12'h000, r);
         apb(0, 12'h000, 0, {1'b0, r & 32'hFF83_FFFF});
      end
      apb(1, 12'h000, 32'h8000_0110);
      chk("edge pol", 2'b01, {effClockEdge, effClockPolarity});
      apb(0, 12'h008, 0, {1'b1, 32'h0});
      for (int c = 0; c < 6; c++) begin
         expSel = {1'b1, c[0]};
         starts = 0;
         apb(1, 12'h000, {2'b10, c[0], 1'b0, c[1], c[2:0], 8'h00, 16'h8000});
         txActive <= 1;
         repeat (32) begin
            repeat (15) @(posedge clk);
            charDone <= 1;
            @(posedge clk);
            charDone <= 0;
         end
         txActive <= 0;
         repeat (20) @(posedge clk);
         chk("frames", 32 >> c, starts);
      end
      expSel = 2'b00;
      apb(1, 12'h000, 32'hC000_8000);
      // Mode switch may show a start while the released pin settles
      repeat (10) @(posedge clk);
      starts = 0;
      // Pulse held three cycles so the synchroniser's last two stages agree
      @(posedge clk) fire <= 1;
      repeat (3) @(posedge clk);
      fire <= 0;
      repeat (10) @(posedge clk);
      chk("slave", 1, starts);
      apb(1, 12'h000, 32'h3F00_80A0);
      starts = 0;
      txActive <= 1;
      repeat (3) @(posedge clk);
      chk("auto on", 2'b11, {selectOe, selectOut});
      txActive <= 0;
      repeat (3) @(posedge clk);
      chk("auto off", 2'b10, {selectOe, selectOut});
      chk("no frames", 0, starts);
      ticks = 0;
      repeat (80) @(posedge clk);
      chk("ticks", 10, ticks);
      wrap_up();
   end
endmodule : tb
